// >>> rtl/lcd_inhibit_map.svh
// Offsets, field positions, reset values and timing counts for the
// inhibit and pin control block. Assumes frame bit n is the n-th bit received.
`ifndef LCD_INHIBIT_MAP_SVH
`define LCD_INHIBIT_MAP_SVH

// Serial frame layout: 8 address bits then instruction data bits D0..D119
`define LKI_FRAME_BITS 8'h80
`define LKI_ADDR_LSB 0
`define LKI_DATA_LSB 8
// Device address on the serial link; value is arbitrary
`define LKI_DEV_ADDR 8'h5a

// Opcode nibble sits in D116..D119, D119 as its top bit
`define LKI_OP_LSB 124
`define LKI_OP_TECH 4'h8
`define LKI_OP_PORT 4'h9
// Display technique fields: D112 nine-common select, D115 external clock
`define LKI_DT_BIT 120
`define LKI_OC_BIT 123
// Port state fields: D0..D2 port select, D3..D5 port levels
`define LKI_PSEL_LSB 8
`define LKI_PLVL_LSB 11

// Reset values
`define LKI_TECH_RST 2'h0
`define LKI_PORT_RST 6'h00

// Timing: frame tick from the RC oscillator rate and the system clock rate
`define LKI_REF_KHZ 50000
`define LKI_RC_KHZ 300
`define LKI_RC_DIV (`LKI_REF_KHZ / `LKI_RC_KHZ)
// Ticks each scan line is driven before its returns are sampled
`define LKI_SCAN_DWELL 4'h4

`endif

// >>> rtl/lcd_inhibit_pkg.sv
// Types shared by the inhibit and pin control block.
// Assumes the constants header supplies all numeric layout.
package lcd_inhibit_pkg;

    // Display technique state programmed over the serial link
    typedef struct packed {
        logic ext_clk;
        logic nine_com;
    } tech_cfg_s;

    // Port state: which shared scan lines are ports, and their levels
    typedef struct packed {
        logic [2:0] sel;
        logic [2:0] lvl;
    } port_cfg_s;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_RUN = 2'b01,
        SCAN_HOLD = 2'b10
    } scan_state_e;

endpackage

// >>> rtl/lcd_key_inhibit_pin_control.sv
// Inhibit and dual-use pin control for a dot-matrix LCD driver with key scan.
// Assumes segment patterns come from display logic on ref_clk, and that the
// host keeps serial_clock still outside frames.
// Contract
// - Inhibit low blanks all segments and commons
// - Inhibit low forces the three ports low
// - Inhibit low stops scanning, scan lines low
// - Inhibit low clears all stored key data
// - Serial receive keeps working during inhibit
// - Inhibit high: normal display, scan, programmed ports
// - Shared pin is ninth common or segment 65
// - Scan lines 1, 2, 7 may become ports
// - RC oscillator default, external clock by instruction
// - Key returns active high, open reads zero
// - Host link: enable, clock, data, data return
// - Sample on clock rise, commit on enable fall
`include "lcd_inhibit_map.svh"

module lcd_key_inhibit_pin_control #(
    parameter int SEG_COUNT = 64,
    parameter int COM_COUNT = 8,
    parameter int SCAN_LINES = 7,
    parameter int RET_LINES = 5
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic inhibit_n,
    input wire logic chip_enable,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic osc_pin_in,
    input wire logic [RET_LINES-1:0] key_return_in,
    input wire logic [SEG_COUNT:0] seg_pattern,
    output logic [SEG_COUNT-1:0] segment_out,
    output logic [COM_COUNT-1:0] common_out,
    output logic shared_seg_common_pin,
    output logic [SCAN_LINES-1:0] key_scan_out,
    output logic [SCAN_LINES*RET_LINES-1:0] key_data,
    output logic key_ready,
    output logic data_out,
    output logic data_out_oe_n,
    output logic nine_com_mode,
    output logic ext_clk_mode
);

    localparam int FRAME_W = 128;
    localparam logic [11:0] RC_LAST = 12'(`LKI_RC_DIV - 1);
    localparam logic [3:0] LAST_COM8 = 4'(COM_COUNT - 1);
    localparam logic [3:0] LAST_COM9 = 4'(COM_COUNT);
    localparam logic [2:0] LAST_LINE = 3'(SCAN_LINES - 1);

    // Maps a shared scan line to its port index; 3 means scan only
    function automatic logic [1:0] port_of(input int line);
        case (line)
            0: port_of = 2'h0;
            1: port_of = 2'h1;
            6: port_of = 2'h2;
            default: port_of = 2'h3;
        endcase
    endfunction

    // Reset release through two flops
    logic rst_s1, rst_sync_n;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_sync_n <= rst_s1;
        end
    end

    // Link domain: bits shift in on rising serial_clock while enable is high.
    // The counter restarts on the first edge of each frame and is left
    // standing after enable falls, so the system side can read it.
    logic [FRAME_W-1:0] frame_sh;
    logic [7:0] bit_cnt;
    logic frame_armed;
    always_ff @(posedge serial_clock or negedge chip_enable) begin
        if (!chip_enable) begin
            frame_armed <= 1'b1;
        end else begin
            frame_armed <= 1'b0;
        end
    end

    always_ff @(posedge serial_clock) begin
        if (chip_enable) begin
            frame_sh <= {serial_in, frame_sh[FRAME_W-1:1]};
            if (frame_armed) begin
                bit_cnt <= 8'h01;
            end else if (bit_cnt != 8'hff) begin
                bit_cnt <= bit_cnt + 8'h01;
            end
        end
    end

    // Level inputs from outside this clock pass two flops first
    logic ce_s1, ce_s2, ce_s3;
    logic inh_s1, inh_s2;
    logic osc_s1, osc_s2, osc_s3;
    logic [RET_LINES-1:0] kr_s1, kr_s2;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ce_s1 <= 1'b0;
            ce_s2 <= 1'b0;
            ce_s3 <= 1'b0;
            inh_s1 <= 1'b0;
            inh_s2 <= 1'b0;
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            kr_s1 <= '0;
            kr_s2 <= '0;
        end else if (clk_en) begin
            ce_s1 <= chip_enable;
            ce_s2 <= ce_s1;
            ce_s3 <= ce_s2;
            inh_s1 <= inhibit_n;
            inh_s2 <= inh_s1;
            osc_s1 <= osc_pin_in;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            kr_s1 <= key_return_in;
            kr_s2 <= kr_s1;
        end
    end

    // Frame commit: enable falling gates a read of the now static link words.
    // Wrong length or address drops the frame. Inhibit plays no part here.
    logic ce_fall;
    logic frame_ok;
    logic [3:0] frame_op;
    assign ce_fall = ce_s3 && !ce_s2;
    assign frame_ok = (bit_cnt == `LKI_FRAME_BITS)
        && (frame_sh[`LKI_ADDR_LSB +: 8] == `LKI_DEV_ADDR);
    assign frame_op = frame_sh[`LKI_OP_LSB +: 4];

    lcd_inhibit_pkg::tech_cfg_s tech_r;
    lcd_inhibit_pkg::port_cfg_s port_r;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tech_r <= `LKI_TECH_RST;
            port_r <= `LKI_PORT_RST;
        end else if (clk_en && ce_fall && frame_ok) begin
            if (frame_op == `LKI_OP_TECH) begin
                tech_r.nine_com <= frame_sh[`LKI_DT_BIT];
                tech_r.ext_clk <= frame_sh[`LKI_OC_BIT];
            end
            if (frame_op == `LKI_OP_PORT) begin
                port_r.sel <= frame_sh[`LKI_PSEL_LSB +: 3];
                port_r.lvl <= frame_sh[`LKI_PLVL_LSB +: 3];
            end
        end
    end

    // Timing tick: RC divider by default, external oscillator pin edges
    // when selected. The divider free-runs so switching back is glitch free.
    logic [11:0] rc_cnt;
    logic tick_r;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rc_cnt <= 12'h000;
            tick_r <= 1'b0;
        end else if (clk_en) begin
            rc_cnt <= (rc_cnt == RC_LAST) ? 12'h000 : rc_cnt + 12'h001;
            if (tech_r.ext_clk) begin
                tick_r <= osc_s2 && !osc_s3;
            end else begin
                tick_r <= (rc_cnt == RC_LAST);
            end
        end
    end

    // Common scan index; nine commons when the shared pin is a common
    logic [3:0] com_idx;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            com_idx <= 4'h0;
        end else if (clk_en && tick_r) begin
            if (com_idx >= (tech_r.nine_com ? LAST_COM9 : LAST_COM8)) begin
                com_idx <= 4'h0;
            end else begin
                com_idx <= com_idx + 4'h1;
            end
        end
    end

    // Key scan: idle drives all lines and waits for a return; a press runs
    // one pass over the lines, then holds until every key is released.
    lcd_inhibit_pkg::scan_state_e scan_state;
    logic [2:0] line_idx;
    logic [3:0] dwell;
    logic [SCAN_LINES*RET_LINES-1:0] kd_r;
    logic ready_r;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            scan_state <= lcd_inhibit_pkg::SCAN_IDLE;
            line_idx <= 3'h0;
            dwell <= 4'h0;
            kd_r <= '0;
            ready_r <= 1'b0;
        end else if (clk_en) begin
            if (!inh_s2) begin
                // Restart from idle with nothing to report
                scan_state <= lcd_inhibit_pkg::SCAN_IDLE;
                line_idx <= 3'h0;
                dwell <= 4'h0;
                kd_r <= '0;
                ready_r <= 1'b0;
            end else if (tick_r) begin
                case (scan_state)
                    lcd_inhibit_pkg::SCAN_IDLE: begin
                        if (|kr_s2) begin
                            scan_state <= lcd_inhibit_pkg::SCAN_RUN;
                            line_idx <= 3'h0;
                            dwell <= 4'h0;
                            kd_r <= '0;
                            ready_r <= 1'b0;
                        end
                    end
                    lcd_inhibit_pkg::SCAN_RUN: begin
                        if (dwell == `LKI_SCAN_DWELL - 4'h1) begin
                            dwell <= 4'h0;
                            kd_r[line_idx*RET_LINES +: RET_LINES] <= kr_s2;
                            if (line_idx == LAST_LINE) begin
                                scan_state <= lcd_inhibit_pkg::SCAN_HOLD;
                                ready_r <= 1'b1;
                            end else begin
                                line_idx <= line_idx + 3'h1;
                            end
                        end else begin
                            dwell <= dwell + 4'h1;
                        end
                    end
                    lcd_inhibit_pkg::SCAN_HOLD: begin
                        if (!(|kr_s2)) begin
                            scan_state <= lcd_inhibit_pkg::SCAN_IDLE;
                        end
                    end
                    default: begin
                        scan_state <= lcd_inhibit_pkg::SCAN_IDLE;
                    end
                endcase
            end
        end
    end

    // Display drive registers; a zero bit means the lowest drive level
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            segment_out <= '0;
            common_out <= '0;
            shared_seg_common_pin <= 1'b0;
        end else if (clk_en) begin
            if (!inh_s2) begin
                segment_out <= '0;
                common_out <= '0;
                shared_seg_common_pin <= 1'b0;
            end else begin
                segment_out <= seg_pattern[SEG_COUNT-1:0];
                for (int c = 0; c < COM_COUNT; c++) begin
                    common_out[c] <= (com_idx == 4'(c));
                end
                if (tech_r.nine_com) begin
                    shared_seg_common_pin <= (com_idx == LAST_COM9);
                end else begin
                    shared_seg_common_pin <= seg_pattern[SEG_COUNT];
                end
            end
        end
    end

    // Scan line pins; each shared line picks scan or port duty
    genvar g;
    generate
        for (g = 0; g < SCAN_LINES; g++) begin : g_line
            localparam logic [1:0] PIDX = port_of(g);
            localparam int PSAFE = (PIDX == 2'h3) ? 0 : int'(PIDX); // Keeps selects in range
            wire logic scan_drive = (scan_state != lcd_inhibit_pkg::SCAN_RUN)
                || (line_idx == 3'(g));
            always_ff @(posedge ref_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    key_scan_out[g] <= 1'b0;
                end else if (clk_en) begin
                    if (!inh_s2) begin
                        key_scan_out[g] <= 1'b0;
                    end else if (PIDX != 2'h3 && port_r.sel[PSAFE]) begin
                        key_scan_out[g] <= port_r.lvl[PSAFE];
                    end else begin
                        key_scan_out[g] <= scan_drive;
                    end
                end
            end
        end
    endgenerate

    // Status outputs; data return pulls low while fresh key data waits
    // outside a frame, so the host sees it between instructions
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            key_data <= '0;
            key_ready <= 1'b0;
            data_out <= 1'b0;
            data_out_oe_n <= 1'b1;
            nine_com_mode <= 1'b0;
            ext_clk_mode <= 1'b0;
        end else if (clk_en) begin
            key_data <= kd_r;
            key_ready <= ready_r;
            data_out <= 1'b0;
            data_out_oe_n <= !(ready_r && !ce_s2);
            nine_com_mode <= tech_r.nine_com;
            ext_clk_mode <= tech_r.ext_clk;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    AST_BLANK_ON_INHIBIT: assert property (
        !inh_s2 && clk_en |=> segment_out == '0 && common_out == '0
            && !shared_seg_common_pin)
        else $error("display not blanked during inhibit");
    AST_LINES_LOW_ON_INHIBIT: assert property (
        !inh_s2 && clk_en |=> key_scan_out == '0)
        else $error("scan or port line high during inhibit");
    AST_KEYDATA_CLEAR: assert property (
        !inh_s2 && clk_en ##1 clk_en |=> key_data == '0 && !key_ready)
        else $error("key data survives inhibit");
    AST_RESUME_IDLE: assert property (
        $rose(inh_s2) |-> scan_state == lcd_inhibit_pkg::SCAN_IDLE && kd_r == '0)
        else $error("scan did not restart idle after inhibit");
    AST_COMMIT_IN_INHIBIT: assert property (
        clk_en && ce_fall && frame_ok && frame_op == `LKI_OP_PORT
            |=> port_r.sel == $past(frame_sh[`LKI_PSEL_LSB +: 3]))
        else $error("port instruction not committed");
    AST_NINTH_COMMON: assert property (
        clk_en && inh_s2 && tech_r.nine_com && com_idx == LAST_COM9
            |=> shared_seg_common_pin && common_out == '0)
        else $error("shared pin not acting as ninth common");
    AST_PORT_LEVEL: assert property (
        clk_en && inh_s2 && port_r.sel[2] |=> key_scan_out[6] == $past(port_r.lvl[2]))
        else $error("port line not at programmed level");
    AST_MIDDLE_ALWAYS_SCAN: assert property (
        clk_en && inh_s2 && scan_state == lcd_inhibit_pkg::SCAN_IDLE
            |=> key_scan_out[5:2] == 4'hf)
        else $error("scan-only line not driven in idle");
    AST_RC_TICK_PERIOD: assert property (
        clk_en && tick_r && !$past(tech_r.ext_clk) |-> $past(rc_cnt) == RC_LAST)
        else $error("tick off the RC divider");
    AST_OPEN_KEYS_IDLE: assert property (
        clk_en && inh_s2 && tick_r && kr_s2 == '0
            && scan_state == lcd_inhibit_pkg::SCAN_IDLE
            |=> scan_state == lcd_inhibit_pkg::SCAN_IDLE)
        else $error("scan started with all keys open");

    COV_SCAN_DONE: cover property (
        scan_state == lcd_inhibit_pkg::SCAN_RUN ##1 scan_state == lcd_inhibit_pkg::SCAN_HOLD);
    COV_INHIBIT_DURING_SCAN: cover property (
        scan_state == lcd_inhibit_pkg::SCAN_RUN && !inh_s2);
    COV_TECH_COMMIT: cover property (ce_fall && frame_ok && frame_op == `LKI_OP_TECH);
    COV_EXT_CLK_TICK: cover property (tick_r && tech_r.ext_clk);

endmodule

// >>> test/host_link_model.sv
// Host side of the three-wire serial link, driving whole 128-bit frames.
// Assumes its own 12 ns link clock, unrelated to the system clock.
module host_link_model (
    output logic chip_enable,
    output logic serial_clock,
    output logic serial_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link idles with the clock still and the enable low; the short enable
    // pulse at start gives the frame counter a falling edge to arm on
    initial begin
        chip_enable = 1'b1;
        serial_clock = 1'b0;
        serial_in = 1'b0;
        #1 chip_enable = 1'b0;
    end

    // Bit 0 goes first; data changes only while the clock is low
    task automatic send_frame(input logic [127:0] bits);
        #3 chip_enable = 1'b1;
        #200;
        for (int k = 0; k < 128; k++) begin
            serial_in = bits[k];
            #6 serial_clock = 1'b1;
            #6 serial_clock = 1'b0;
        end
        #200 chip_enable = 1'b0;
        // Released data line must not keep looking valid
        serial_in = ~serial_in;
        #400; // Spacing well past execution time
    endtask
endmodule

// >>> test/lcd_key_inhibit_pin_control_bench.sv
// Self-checking bench for the inhibit and pin control block.
// Assumes the host link model and the design's constants header.
`include "lcd_inhibit_map.svh"

module lcd_key_inhibit_pin_control_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic inhibit_n = 1'b0;
    logic osc_pin_in = 1'b0;
    logic pressed = 1'b0;
    logic [4:0] key_return_in = 5'h00;
    logic [64:0] seg_pattern = {1'b1, 64'hc3a5_5a3c_0ff0_f00f};
    logic chip_enable, serial_clock, serial_in, data_line;
    logic [63:0] segment_out;
    logic [7:0] common_out;
    logic shared_seg_common_pin, key_ready, data_out, data_out_oe_n;
    logic [6:0] key_scan_out;
    logic [34:0] key_data;
    logic nine_com_mode, ext_clk_mode;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;

    always #10 ref_clk = ~ref_clk;

    // Open-drain data return with its pull-up
    assign data_line = data_out_oe_n ? 1'b1 : data_out;

    // Key matrix: one key between scan line 3 and return 3, active high
    always @(posedge ref_clk) begin
        key_return_in <= (pressed && key_scan_out[2]) ? 5'h04 : 5'h00;
    end

    host_link_model u_host_link_model (
        .chip_enable(chip_enable),
        .serial_clock(serial_clock),
        .serial_in(serial_in)
    );

    lcd_key_inhibit_pin_control u_lcd_key_inhibit_pin_control (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .inhibit_n(inhibit_n),
        .chip_enable(chip_enable), .serial_clock(serial_clock), .serial_in(serial_in),
        .osc_pin_in(osc_pin_in), .key_return_in(key_return_in), .seg_pattern(seg_pattern),
        .segment_out(segment_out), .common_out(common_out),
        .shared_seg_common_pin(shared_seg_common_pin), .key_scan_out(key_scan_out),
        .key_data(key_data), .key_ready(key_ready), .data_out(data_out),
        .data_out_oe_n(data_out_oe_n), .nine_com_mode(nine_com_mode),
        .ext_clk_mode(ext_clk_mode)
    );

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cut a hang short; the whole run needs well under a third of this
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Settle one nanosecond past the edge so reads and drives never race
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Opcode plus the low six data bits and the two technique fields
    task automatic send(input logic [7:0] addr, input logic [3:0] op, input logic [5:0] low,
                        input logic dt, input logic oc);
        logic [127:0] f;
        f = '0;
        f[7:0] = addr;
        f[`LKI_OP_LSB +: 4] = op;
        f[`LKI_PSEL_LSB +: 3] = low[2:0];
        f[`LKI_PLVL_LSB +: 3] = low[5:3];
        f[`LKI_DT_BIT] = dt;
        f[`LKI_OC_BIT] = oc;
        u_host_link_model.send_frame(f);
        cyc(10);
    endtask

    // One external clock tick, held long enough to pass the synchroniser
    task automatic osc_tick();
        osc_pin_in <= 1'b1;
        cyc(6);
        osc_pin_in <= 1'b0;
        cyc(8);
    endtask

    task automatic t_inhibit_link();
        // Technique goes first after power-on
        send(`LKI_DEV_ADDR, `LKI_OP_TECH, 6'h00, 1'b0, 1'b1);
        check("ext_clk_mode", 64'(ext_clk_mode), 64'h1);
        check("nine_com_mode", 64'(nine_com_mode), 64'h0);
        // Ports P1..P3 selected, levels 1,0,1
        send(`LKI_DEV_ADDR, `LKI_OP_PORT, 6'h2f, 1'b0, 1'b0);
        send(8'h00, `LKI_OP_TECH, 6'h00, 1'b1, 1'b1);
        check("foreign_frame", 64'(nine_com_mode), 64'h0);
        check("segment_out", segment_out, 64'h0);
        check("common_out", 64'(common_out), 64'h0);
        check("shared_pin", 64'(shared_seg_common_pin), 64'h0);
        check("key_scan_out", 64'(key_scan_out), 64'h0);
        check("key_data", 64'(key_data), 64'h0);
        $display("test inhibit_link done");
    endtask

    task automatic t_display();
        logic [7:0] c, acc;
        acc = 8'h00;
        inhibit_n <= 1'b1;
        cyc(10);
        check("ports_and_scan", 64'(key_scan_out), 64'h7d);
        check("segment_out", segment_out, seg_pattern[63:0]);
        // External mode: no ticks while the clock pin is still
        c = common_out;
        cyc(400);
        check("commons_still", 64'(common_out), 64'(c));
        for (int i = 0; i < 8; i++) begin
            osc_tick();
            check("one_common", 64'($countones(common_out)), 64'h1);
            check("shared_is_seg", 64'(shared_seg_common_pin), 64'h1);
            acc |= common_out;
        end
        check("all_commons", 64'(acc), 64'hff);
        $display("test display done");
    endtask

    task automatic t_nine_com();
        logic [8:0] v, acc;
        int hits;
        acc = 9'h000;
        hits = 0;
        seg_pattern[64] <= 1'b0;
        send(`LKI_DEV_ADDR, `LKI_OP_TECH, 6'h00, 1'b1, 1'b1);
        check("nine_com_mode", 64'(nine_com_mode), 64'h1);
        for (int i = 0; i < 9; i++) begin
            osc_tick();
            v = {shared_seg_common_pin, common_out};
            check("one_of_nine", 64'($countones(v)), 64'h1);
            acc |= v;
            hits += int'(shared_seg_common_pin);
        end
        check("ninth_slots", 64'(hits), 64'h1);
        check("all_nine", 64'(acc), 64'h1ff);
        $display("test nine_com done");
    endtask

    task automatic t_rc_clock();
        logic [7:0] c;
        int i;
        send(`LKI_DEV_ADDR, `LKI_OP_TECH, 6'h00, 1'b0, 1'b0);
        check("ext_clk_mode", 64'(ext_clk_mode), 64'h0);
        c = common_out;
        for (i = 0; i < 400 && common_out === c; i++) cyc(1);
        check("rc_ticks", 64'(common_out !== c), 64'h1);
        // Ports released: the shared lines go back to scan duty
        send(`LKI_DEV_ADDR, `LKI_OP_PORT, 6'h00, 1'b0, 1'b0);
        check("lines_scan_duty", 64'(key_scan_out), 64'h7f);
        $display("test rc_clock done");
    endtask

    task automatic t_keys();
        int i;
        pressed <= 1'b1;
        for (i = 0; i < 12000 && key_ready !== 1'b1; i++) cyc(1);
        check("key_ready", 64'(key_ready), 64'h1);
        check("key_data", 64'(key_data), 64'h1000);
        check("data_return", 64'(data_line), 64'h0);
        check("data_out", 64'(data_out), 64'h0);
        pressed <= 1'b0;
        inhibit_n <= 1'b0;
        cyc(6);
        check("key_data_cleared", 64'(key_data), 64'h0);
        check("ready_cleared", 64'(key_ready), 64'h0);
        check("scan_stopped", 64'(key_scan_out), 64'h0);
        inhibit_n <= 1'b1;
        cyc(6);
        check("scan_idle", 64'(key_scan_out[5:2]), 64'hf);
        check("no_stale_key", 64'({key_ready, key_data}), 64'h0);
        $display("test keys done");
    endtask

    // Reset 16 cycles with inhibit low, then the scenarios in order
    initial begin
        cyc(10);
        check("oe_n_in_reset", 64'(data_out_oe_n), 64'h1);
        check("scan_in_reset", 64'(key_scan_out), 64'h0);
        cyc(6);
        rst_n <= 1'b1;
        cyc(5);
        t_inhibit_link();
        t_display();
        t_nine_com();
        t_rc_clock();
        t_keys();
        summarize();
    end
endmodule
